//--- hdl/irq_enable_pkg.sv
// Package: register map, field layout and carrier types for the interrupt-enable bank
package irq_enable_pkg;
	localparam int unsigned ADDR_W = 8;
	localparam logic [ADDR_W-1:0] OFS_ENABLE = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_ENABLE_CLR = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_ENABLE_SET = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_ENABLE_INV = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_STATUS_MASK = 8'h14;
	localparam int unsigned SRC_N = 10;
	localparam int unsigned BIT_OVFL = 0;
	localparam int unsigned BIT_BUFNA = 1;
	localparam int unsigned BIT_TRANSMIT_ABORT_FLAG = 2;
	localparam int unsigned BIT_TRANSMIT_DONE_FLAG = 3;
	localparam int unsigned BIT_RSVD = 4;
	localparam int unsigned BIT_RECEIVE_ACTIVITY_FLAG = 5;
	localparam int unsigned BIT_PACKET_PENDING_FLAG = 6;
	localparam int unsigned BIT_RECEIVE_DONE_FLAG = 7;
	localparam int unsigned BIT_FWM = 8;
	localparam int unsigned BIT_EWM = 9;
	// Implemented enable bits: 9..5 and 3..0; bit 4 reserved
	localparam logic [31:0] ENABLE_VALID = 32'h0000_03EF;
	localparam logic [31:0] ENABLE_RESET = 32'h0000_0000;
	localparam logic [31:0] STATUS_VALID = 32'h0000_0003;
	localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
	localparam int unsigned EV_REQ = 0;
	localparam int unsigned EV_BADADDR = 1;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [31:0] pwdata;
	} apb_req_t;

	typedef enum logic [1:0] {
		OP_NONE,
		OP_CLR,
		OP_SET,
		OP_INV
	} alias_op_t;
endpackage

//--- hdl/irq_gate.sv
// Gate of source flags by their enables into one request
`timescale 1ns/10ps
`default_nettype none
module irq_gate
	import irq_enable_pkg::*;
#(
	parameter int unsigned N = SRC_N
) (
	input wire logic [N-1:0] flag_in,
	input wire logic [N-1:0] enable_in,
	output logic [N-1:0] pending_out,
	output logic request_out
);
	genvar i;
	generate
		for (i = 0; i < N; i++) begin : g_src
			assign pending_out[i] = flag_in[i] & enable_in[i];
		end
	endgenerate
	assign request_out = |pending_out;
endmodule
`default_nettype wire

//--- hdl/irq_enable_bank.sv
// Interrupt-enable register bank with clear/set/invert aliases on APB
// Functional notes
// - A write to the clear alias at +0x4 zeroes each implemented enable bit written as one.
// - A write to the set alias at +0x8 sets each implemented enable bit written as one.
// - A write to the invert alias at +0xC toggles each implemented enable bit written as one.
// - Bit 6 gates the packet-pending interrupt.
// - Bit 5 gates the receive-activity interrupt.
// - Bit 3 gates the transmit-done interrupt.
// - Bit 2 gates the transmit-abort interrupt.
// - Bit 1 gates the receive-buffer-not-available interrupt.
// - Bit 0 gates the receive-FIFO-overflow interrupt.
// - Bits 9 and 8 gate the empty- and full-watermark interrupts.
// - Bit 7 gates the receive-done interrupt.
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
module irq_enable_bank
	import irq_enable_pkg::*;
(
	// Clock, reset, enable
	input wire logic CLK_IN,
	input wire logic RST_N_IN,
	input wire logic CLK_EN_IN,
	// APB slave
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic PWRITE_IN,
	input wire logic [ADDR_W-1:0] PADDR_IN,
	input wire logic [31:0] PWDATA_IN,
	output logic [31:0] PRDATA_OUT,
	output logic PREADY_OUT,
	output logic PSLVERR_OUT,
	// Source flags from the controller
	input wire logic [SRC_N-1:0] FLAG_IN,
	// Interrupt outputs
	output logic CTRL_IRQ_OUT,
	output logic BANK_IRQ_OUT
);
	apb_req_t req;
	logic [SRC_N-1:0] enable;
	logic [SRC_N-1:0] pending;
	logic ctrl_irq;
	logic [1:0] status;
	logic [1:0] status_mask;
	logic access;
	logic wr;
	logic rd;
	logic hit;
	alias_op_t op;
	logic [SRC_N-1:0] wmask;
	logic [SRC_N-1:0] next_enable;
	logic [1:0] ev;
	logic [31:0] next_rdata;

	assign req = '{psel: PSEL_IN, penable: PENABLE_IN, pwrite: PWRITE_IN,
		paddr: PADDR_IN, pwdata: PWDATA_IN};
	// Zero-wait slave: every access phase completes at once
	assign PREADY_OUT = 1'b1;
	assign access = req.psel & req.penable & CLK_EN_IN;
	assign wr = access & req.pwrite;
	assign rd = access & ~req.pwrite;
	assign hit = (req.paddr == OFS_ENABLE) || (req.paddr == OFS_ENABLE_CLR)
		|| (req.paddr == OFS_ENABLE_SET) || (req.paddr == OFS_ENABLE_INV)
		|| (req.paddr == OFS_STATUS) || (req.paddr == OFS_STATUS_MASK);
	assign PSLVERR_OUT = req.psel & req.penable & ~hit;
	// Reserved bit never stored, whatever software writes
	assign wmask = req.pwdata[SRC_N-1:0] & ENABLE_VALID[SRC_N-1:0];

	always_comb begin
		op = OP_NONE;
		if (wr && req.paddr == OFS_ENABLE_CLR) begin
			op = OP_CLR;
		end else if (wr && req.paddr == OFS_ENABLE_SET) begin
			op = OP_SET;
		end else if (wr && req.paddr == OFS_ENABLE_INV) begin
			op = OP_INV;
		end
	end

	always_comb begin
		next_enable = enable;
		if (wr && req.paddr == OFS_ENABLE) begin
			next_enable = wmask;
		end
		unique case (op)
			OP_NONE: begin
			end
			OP_CLR: begin
				next_enable = enable & ~wmask;
			end
			OP_SET: begin
				next_enable = enable | wmask;
			end
			OP_INV: begin
				next_enable = enable ^ wmask;
			end
		endcase
	end

	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			enable <= ENABLE_RESET[SRC_N-1:0];
		end else if (CLK_EN_IN) begin
			enable <= next_enable;
		end
	end

	// Bits 9..5, 3..0 each gate their own flag
	irq_gate #(
		.N(SRC_N)
	) u_gate (
		.flag_in(FLAG_IN),
		.enable_in(enable),
		.pending_out(pending),
		.request_out(ctrl_irq)
	);

	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			CTRL_IRQ_OUT <= 1'b0;
		end else if (CLK_EN_IN) begin
			CTRL_IRQ_OUT <= ctrl_irq;
		end
	end

	// Bank events: a rising edge of the controller request, and an unmapped address hit
	assign ev[EV_REQ] = ctrl_irq & ~CTRL_IRQ_OUT;
	assign ev[EV_BADADDR] = access & ~hit;

	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			status <= 2'h0;
		end else if (CLK_EN_IN) begin
			// Set wins over a simultaneous write-one clear
			if (wr && req.paddr == OFS_STATUS) begin
				status <= (status & ~req.pwdata[1:0]) | ev;
			end else begin
				status <= status | ev;
			end
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			status_mask <= 2'h0;
		end else if (CLK_EN_IN && wr && req.paddr == OFS_STATUS_MASK) begin
			status_mask <= req.pwdata[1:0];
		end
	end

	assign BANK_IRQ_OUT = |(status & status_mask);

	always_comb begin
		next_rdata = WORD_ZERO;
		// Alias locations read as zero; software reads the enable register
		if (req.paddr == OFS_ENABLE) begin
			next_rdata[SRC_N-1:0] = enable;
		end else if (req.paddr == OFS_STATUS) begin
			next_rdata[1:0] = status;
		end else if (req.paddr == OFS_STATUS_MASK) begin
			next_rdata[1:0] = status_mask;
		end
	end

	// Read data registered during setup so it is steady in the access phase
	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			PRDATA_OUT <= WORD_ZERO;
		end else if (CLK_EN_IN && req.psel && !req.penable && !req.pwrite) begin
			PRDATA_OUT <= next_rdata;
		end
	end

	logic rd_unused;
	assign rd_unused = rd;

	chk_clear_alias: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
		(wr && req.paddr == OFS_ENABLE_CLR) |=> ((enable & $past(wmask)) == '0)
			&& ((enable | $past(wmask)) == ($past(enable) | $past(wmask))))
		else $error("clear alias did not clear written bits only");
	chk_set_alias: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
		(wr && req.paddr == OFS_ENABLE_SET) |=> (enable == ($past(enable) | $past(wmask))))
		else $error("set alias result wrong");
	chk_inv_alias: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
		(wr && req.paddr == OFS_ENABLE_INV) |=> (enable == ($past(enable) ^ $past(wmask))))
		else $error("invert alias result wrong");
	chk_alias_read_zero: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
		(CLK_EN_IN && req.psel && !req.penable && !req.pwrite
			&& req.paddr == OFS_ENABLE_SET) |=> (PRDATA_OUT == WORD_ZERO))
		else $error("alias read returned data");
	chk_rsvd_bit_zero: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
		enable[BIT_RSVD] == 1'b0)
		else $error("reserved enable bit set");
	chk_packet_pending_flag_gate: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
		(CLK_EN_IN && FLAG_IN == (SRC_N'(1) << BIT_PACKET_PENDING_FLAG))
			|=> (CTRL_IRQ_OUT == $past(enable[BIT_PACKET_PENDING_FLAG])))
		else $error("packet pending gating wrong");
	chk_irq_level: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
		CLK_EN_IN |=> (CTRL_IRQ_OUT == |($past(FLAG_IN) & $past(enable))))
		else $error("controller request does not follow enabled flags");
	chk_status_sticky: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
		(status[EV_BADADDR] && !(wr && req.paddr == OFS_STATUS)) |=> status[EV_BADADDR])
		else $error("status bit lost without a clear");

	// Per-source gating: a lone flag reaches the request only through its own enable
	chk_receive_activity_flag_gate: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
		(CLK_EN_IN && FLAG_IN == (SRC_N'(1) << BIT_RECEIVE_ACTIVITY_FLAG))
			|=> (CTRL_IRQ_OUT == $past(enable[BIT_RECEIVE_ACTIVITY_FLAG])))
		else $error("receive activity gating wrong");
	chk_transmit_done_flag_gate: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
		(CLK_EN_IN && FLAG_IN == (SRC_N'(1) << BIT_TRANSMIT_DONE_FLAG))
			|=> (CTRL_IRQ_OUT == $past(enable[BIT_TRANSMIT_DONE_FLAG])))
		else $error("transmit done gating wrong");
	chk_transmit_abort_flag_gate: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
		(CLK_EN_IN && FLAG_IN == (SRC_N'(1) << BIT_TRANSMIT_ABORT_FLAG))
			|=> (CTRL_IRQ_OUT == $past(enable[BIT_TRANSMIT_ABORT_FLAG])))
		else $error("transmit abort gating wrong");
	chk_bufna_gate: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
		(CLK_EN_IN && FLAG_IN == (SRC_N'(1) << BIT_BUFNA))
			|=> (CTRL_IRQ_OUT == $past(enable[BIT_BUFNA])))
		else $error("buffer unavailable gating wrong");
	chk_ovfl_gate: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
		(CLK_EN_IN && FLAG_IN == (SRC_N'(1) << BIT_OVFL))
			|=> (CTRL_IRQ_OUT == $past(enable[BIT_OVFL])))
		else $error("fifo overflow gating wrong");
	chk_ewm_gate: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
		(CLK_EN_IN && FLAG_IN == (SRC_N'(1) << BIT_EWM))
			|=> (CTRL_IRQ_OUT == $past(enable[BIT_EWM])))
		else $error("empty watermark gating wrong");
	chk_fwm_gate: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
		(CLK_EN_IN && FLAG_IN == (SRC_N'(1) << BIT_FWM))
			|=> (CTRL_IRQ_OUT == $past(enable[BIT_FWM])))
		else $error("full watermark gating wrong");
	chk_receive_done_flag_gate: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
		(CLK_EN_IN && FLAG_IN == (SRC_N'(1) << BIT_RECEIVE_DONE_FLAG))
			|=> (CTRL_IRQ_OUT == $past(enable[BIT_RECEIVE_DONE_FLAG])))
		else $error("receive done gating wrong");
	chk_pending_vector: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
		CLK_EN_IN
			|=> (CTRL_IRQ_OUT == |$past(pending)))
		else $error("pending vector and request disagree");

	// Register side: writes land only where addressed, and never while frozen
	chk_direct_write: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
		(wr && req.paddr == OFS_ENABLE)
			|=> (enable == $past(wmask)))
		else $error("direct enable write wrong");
	chk_enable_hold: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
		(!wr)
			|=> (enable == $past(enable)))
		else $error("enable changed without a write");
	chk_freeze_state: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
		(!CLK_EN_IN)
			|=> (status == $past(status)) && (CTRL_IRQ_OUT == $past(CTRL_IRQ_OUT)))
		else $error("state moved while clock enable low");
	chk_clr_read_zero: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
		(CLK_EN_IN && req.psel && !req.penable && !req.pwrite
			&& req.paddr == OFS_ENABLE_CLR) |=> (PRDATA_OUT == WORD_ZERO))
		else $error("clear alias read returned data");
	chk_inv_read_zero: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
		(CLK_EN_IN && req.psel && !req.penable && !req.pwrite
			&& req.paddr == OFS_ENABLE_INV) |=> (PRDATA_OUT == WORD_ZERO))
		else $error("invert alias read returned data");

	// Bank status: both events must latch, and an unmapped access must report an error
	chk_bad_addr_err: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
		(access && !hit)
			|-> PSLVERR_OUT)
		else $error("unmapped access without error response");
	chk_bad_addr_flag: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
		(access && !hit)
			|=> status[EV_BADADDR])
		else $error("unmapped access not latched");
	chk_req_edge_flag: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
		(CLK_EN_IN && ev[EV_REQ])
			|=> status[EV_REQ])
		else $error("request rising edge not latched");
	chk_bank_irq_off: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
		((status & status_mask) == 2'h0)
			|-> !BANK_IRQ_OUT)
		else $error("bank interrupt high with nothing unmasked");
endmodule
`default_nettype wire

//--- sim/test_irq_enable_bank.sv
// Self-checking bench for the interrupt-enable bank
`timescale 1ns/10ps
`default_nettype none
module test_irq_enable_bank
	import irq_enable_pkg::*;
;
	logic clk, rst_n, clk_en, psel, penable, pwrite, pready, pslverr, ctrl_irq, bank_irq;
	logic [ADDR_W-1:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [SRC_N-1:0] flag;
	logic last_err;
	int num_errors = 0;
	int checks_done = 0;

	irq_enable_bank u_irq_enable_bank (.CLK_IN(clk), .RST_N_IN(rst_n), .CLK_EN_IN(clk_en),
		.PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr),
		.PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
		.PSLVERR_OUT(pslverr), .FLAG_IN(flag), .CTRL_IRQ_OUT(ctrl_irq),
		.BANK_IRQ_OUT(bank_irq));

	always #50 clk = ~clk;

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e) begin
			num_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, s, e);
		end
	endtask

	// Waits for pready under a bound; no wait-state count is assumed
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) num_errors++;
		r = prdata;
		last_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] r;
		bus(1'b0, a, WORD_ZERO, r);
		chk(r, e);
	endtask

	task automatic t_reset;
		rd_chk(OFS_ENABLE, ENABLE_RESET);
		rd_chk(OFS_STATUS_MASK, WORD_ZERO);
		$display("test reset done");
	endtask

	task automatic t_alias;
		logic [31:0] r;
		bus(1'b1, OFS_ENABLE, 32'hFFFF_FFEF, r);
		rd_chk(OFS_ENABLE, 32'h0000_03EF);
		bus(1'b1, OFS_ENABLE_CLR, 32'h0000_0021, r);
		rd_chk(OFS_ENABLE, 32'h0000_03CE);
		bus(1'b1, OFS_ENABLE_SET, 32'hFFFF_FC21, r);
		rd_chk(OFS_ENABLE, 32'h0000_03EF);
		bus(1'b1, OFS_ENABLE_INV, 32'h0000_0FEF, r);
		rd_chk(OFS_ENABLE, 32'h0000_0000);
		bus(1'b1, OFS_ENABLE_INV, 32'h0000_02A5, r);
		rd_chk(OFS_ENABLE, 32'h0000_02A5);
		rd_chk(OFS_ENABLE_SET, WORD_ZERO);
		// Clock enable low: the set write must not be taken
		@(posedge clk) clk_en <= 1'b0;
		bus(1'b1, OFS_ENABLE_SET, 32'h0000_0002, r);
		clk_en <= 1'b1;
		rd_chk(OFS_ENABLE, 32'h0000_02A5);
		$display("test alias done");
	endtask

	// One enable at a time; the other flags are high while its own is low, to catch crosstalk
	task automatic t_gate;
		logic [31:0] r;
		for (int i = 0; i < 10; i++) if (i != BIT_RSVD) begin
			bus(1'b1, OFS_ENABLE, 32'h1 << i, r);
			@(posedge clk) flag <= ~(10'h1 << i);
			repeat (2) @(posedge clk);
			@(negedge clk) chk({31'h0, ctrl_irq}, 32'h0);
			@(posedge clk) flag <= 10'h3FF;
			repeat (2) @(posedge clk);
			@(negedge clk) chk({31'h0, ctrl_irq}, 32'h1);
			@(posedge clk) flag <= 10'h1 << i;
			repeat (2) @(posedge clk);
			@(negedge clk) chk({31'h0, ctrl_irq}, 32'h1);
		end
		@(posedge clk) flag <= 10'h3FF;
		$display("test gate done");
	endtask

	task automatic t_irq;
		logic [31:0] r;
		bus(1'b1, OFS_ENABLE, WORD_ZERO, r);
		bus(1'b1, OFS_STATUS, 32'h0000_0003, r);
		rd_chk(OFS_STATUS, WORD_ZERO);
		bus(1'b1, OFS_ENABLE_SET, 32'h0000_0001, r);
		repeat (3) @(posedge clk);
		rd_chk(OFS_STATUS, 32'h0000_0001);
		chk({31'h0, bank_irq}, 32'h0);
		bus(1'b1, OFS_STATUS_MASK, 32'h0000_0001, r);
		@(negedge clk) chk({31'h0, bank_irq}, 32'h1);
		bus(1'b1, OFS_STATUS, 32'h0000_0001, r);
		@(negedge clk) chk({31'h0, bank_irq}, 32'h0);
		rd_chk(8'h20, WORD_ZERO);
		chk({31'h0, last_err}, 32'h1);
		rd_chk(OFS_STATUS, 32'h0000_0002);
		$display("test irq done");
	endtask

	task automatic end_sim;
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		rst_n = 1'b0;
		clk_en = 1'b1;
		{psel, penable, pwrite, last_err} = 4'h0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		flag = 10'h000;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_alias();
		t_gate();
		t_irq();
		end_sim();
	end

	// Whole run is a few hundred cycles
	initial begin
		#(3000 * 100);
		num_errors++;
		end_sim();
	end
endmodule
`default_nettype wire
